// [inc/ata_bridge_pkg.sv]
package ata_bridge_pkg;
    // register index; byte address is four times the index
    localparam logic [4:0] IDX_DATA = 5'h00;
    localparam logic [4:0] IDX_ERROR = 5'h01;
    localparam logic [4:0] IDX_COUNT = 5'h02;
    localparam logic [4:0] IDX_LBA_LOW = 5'h03;
    localparam logic [4:0] IDX_LBA_MID = 5'h04;
    localparam logic [4:0] IDX_LBA_HIGH = 5'h05;
    localparam logic [4:0] IDX_DEVICE = 5'h06;
    localparam logic [4:0] IDX_STATUS = 5'h07;
    localparam logic [4:0] IDX_ALT_STATUS = 5'h0e;
    localparam logic [4:0] IDX_SENSE = 5'h10;
    localparam logic [4:0] IDX_INFO = 5'h11;
    // status bits
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    // error bits
    localparam int ER_ICRC = 7;
    localparam int ER_MC = 5;
    localparam int ER_IDNF = 4;
    localparam int ER_ABRT = 2;
    localparam int ER_NM = 1;
    localparam int DEV_LBA = 6;
    localparam int DC_SRST = 2;
    // command and packet codes
    localparam logic [7:0] CMD_IDENTIFY = 8'hec;
    localparam logic [7:0] CMD_IDENTIFY_PKT = 8'ha1;
    localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
    localparam logic [7:0] CMD_PACKET = 8'ha0;
    localparam logic [7:0] PKT_INQUIRY = 8'h12;
    localparam logic [7:0] PKT_READ_CAPACITY = 8'h25;
    localparam logic [2:0] PKT_WORDS = 3'h6;
    // sense data
    localparam logic [7:0] SK_NOT_READY = 8'h02;
    localparam logic [7:0] SK_HW_ERROR = 8'h04;
    localparam logic [7:0] SK_ILLEGAL = 8'h05;
    localparam logic [7:0] SK_UNIT_ATTN = 8'h06;
    localparam logic [7:0] SK_ABORTED = 8'h0b;
    localparam logic [7:0] ASC_LUN_COMM = 8'h08;
    localparam logic [7:0] ASC_MEDIUM_CHG = 8'h28;
    localparam logic [7:0] ASC_NO_MEDIUM = 8'h3a;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASCQ_NONE = 8'h00;
    localparam int INIT_CYCLES_DEF = 16;

    typedef enum logic [3:0] {
        RES_OK = 4'h0,
        RES_UNSUPPORTED = 4'h1,
        RES_DEV_ERROR = 4'h2,
        RES_DISCONNECTED = 4'h3,
        RES_OUT_OF_RANGE = 4'h4,
        RES_UDMA_CRC = 4'h5,
        RES_MEDIA_CHANGED = 4'h6,
        RES_NO_MEDIA = 4'h7,
        RES_USB_PROTO = 4'h8,
        RES_NO_RESPONSE = 4'h9,
        RES_CONNECTED = 4'ha,
        RES_REMOVED = 4'hb
    } result_e;

    typedef enum logic [2:0] {
        ST_WAIT_LOCK = 3'h0,
        ST_INIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_PACKET = 3'h3,
        ST_EXEC = 3'h4
    } state_e;

    typedef struct packed {
        logic is_packet;
        logic [7:0] code;
        logic [7:0] packet_op;
        logic chs;
        logic [7:0] count;
        logic [27:0] address;
    } cmd_s;

    typedef struct packed {
        logic done;
        result_e result;
    } res_s;
endpackage

// [logic/ata_bridge_status_reporting.sv]
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - after init dasp low while busy or drq, else high
// - during init dasp senses slave presence
// - on normal start busy and lock pin high
// - clear busy when init completes
// - accept identify, set features, inquiry, capacity
// - ata failure sets err with cause bits
// - abort alone for unsupported, error, disconnect
// - abort plus idnf for unreachable address
// - abort plus icrc for ultra dma crc
// - media changed bit on change
// - no media bit when absent
// - packet failure sets chk with sense
// - sense 04/08/00 on usb error, no answer
// - sense 06/28/00 on connect or change
// - sense 02/3a/00 on disconnect or removal
// - task file reachable over local bus
// - no attribute memory present
// - chs addressing accepted besides lba
// - data word access only, others low byte, sense both bytes
// - stay busy on nak until host reset or soft reset
module ata_bridge_status_reporting #(
    parameter int INIT_CYCLES = ata_bridge_pkg::INIT_CYCLES_DEF
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [6:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pll_lock_i,
    input wire logic host_reset_n_i,
    input wire logic dasp_i,
    output logic dasp_o,
    output logic dasp_oe_o,
    output logic general_port_pin_thirteen_o,
    output logic cmd_valid_o,
    output ata_bridge_pkg::cmd_s cmd_o,
    input wire ata_bridge_pkg::res_s res_i
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] lock_sync;
    logic [1:0] hrst_sync;
    logic [1:0] dasp_sync;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_sync <= 2'h0;
            hrst_sync <= 2'h3;
            dasp_sync <= 2'h3;
        end else begin
            lock_sync <= {lock_sync[0], pll_lock_i};
            hrst_sync <= {hrst_sync[0], host_reset_n_i};
            dasp_sync <= {dasp_sync[0], dasp_i};
        end
    end

    logic lock_s;
    logic host_reset_s;
    logic dasp_s;
    assign lock_s = lock_sync[1];
    assign host_reset_s = ~hrst_sync[1];
    assign dasp_s = dasp_sync[1];

    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic [4:0] idx;
    logic req;
    logic wr;
    logic rd;
    logic word_ok;
    assign idx = wb_adr_i[6:2];
    assign req = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign word_ok = (wb_sel_i[1:0] == 2'h3);

    ////////////////////////////////////////////////////////////////////
    // result mapping
    function automatic logic [7:0] ata_error(
        input ata_bridge_pkg::result_e r
    );
        logic [7:0] e;
        e = 8'h00;
        case (r)
            ata_bridge_pkg::RES_OUT_OF_RANGE: begin
                e[ata_bridge_pkg::ER_ABRT] = 1'b1;
                e[ata_bridge_pkg::ER_IDNF] = 1'b1;
            end
            ata_bridge_pkg::RES_UDMA_CRC: begin
                e[ata_bridge_pkg::ER_ABRT] = 1'b1;
                e[ata_bridge_pkg::ER_ICRC] = 1'b1;
            end
            ata_bridge_pkg::RES_MEDIA_CHANGED: begin
                e[ata_bridge_pkg::ER_MC] = 1'b1;
            end
            ata_bridge_pkg::RES_NO_MEDIA: begin
                e[ata_bridge_pkg::ER_NM] = 1'b1;
            end
            ata_bridge_pkg::RES_OK: e = 8'h00;
            default: begin
                e[ata_bridge_pkg::ER_ABRT] = 1'b1;
            end
        endcase
        return e;
    endfunction

    function automatic logic [23:0] sense(
        input ata_bridge_pkg::result_e r
    );
        logic [23:0] s;
        case (r)
            ata_bridge_pkg::RES_USB_PROTO,
            ata_bridge_pkg::RES_NO_RESPONSE: begin
                s = {ata_bridge_pkg::SK_HW_ERROR,
                     ata_bridge_pkg::ASC_LUN_COMM,
                     ata_bridge_pkg::ASCQ_NONE};
            end
            ata_bridge_pkg::RES_CONNECTED,
            ata_bridge_pkg::RES_MEDIA_CHANGED: begin
                s = {ata_bridge_pkg::SK_UNIT_ATTN,
                     ata_bridge_pkg::ASC_MEDIUM_CHG,
                     ata_bridge_pkg::ASCQ_NONE};
            end
            ata_bridge_pkg::RES_DISCONNECTED,
            ata_bridge_pkg::RES_REMOVED,
            ata_bridge_pkg::RES_NO_MEDIA: begin
                s = {ata_bridge_pkg::SK_NOT_READY,
                     ata_bridge_pkg::ASC_NO_MEDIUM,
                     ata_bridge_pkg::ASCQ_NONE};
            end
            ata_bridge_pkg::RES_UNSUPPORTED: begin
                s = {ata_bridge_pkg::SK_ILLEGAL,
                     ata_bridge_pkg::ASC_BAD_OPCODE,
                     ata_bridge_pkg::ASCQ_NONE};
            end
            default: begin
                s = {ata_bridge_pkg::SK_ABORTED, ata_bridge_pkg::ASC_NONE,
                     ata_bridge_pkg::ASCQ_NONE};
            end
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // task file state
    ata_bridge_pkg::state_e state;
    ata_bridge_pkg::state_e next_state;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] error;
    logic [7:0] next_error;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] lba_low;
    logic [7:0] next_lba_low;
    logic [7:0] lba_mid;
    logic [7:0] next_lba_mid;
    logic [7:0] lba_high;
    logic [7:0] next_lba_high;
    logic [7:0] device;
    logic [7:0] next_device;
    logic [7:0] devctl;
    logic [7:0] next_devctl;
    logic [15:0] asc_q;
    logic [15:0] next_asc_q;
    logic [7:0] command;
    logic [7:0] next_command;
    logic [7:0] packet_op;
    logic [7:0] next_packet_op;
    logic [2:0] pkt_words;
    logic [2:0] next_pkt_words;
    logic [15:0] init_cnt;
    logic [15:0] next_init_cnt;
    logic slave_present;
    logic next_slave_present;
    logic lock_pin;
    logic next_lock_pin;
    logic issue;
    logic next_issue;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic ack;
    logic next_ack;

    logic init_done;
    logic abort;
    logic [23:0] sns;
    assign init_done = (state != ata_bridge_pkg::ST_WAIT_LOCK) &&
                       (state != ata_bridge_pkg::ST_INIT);
    assign abort = host_reset_s | devctl[ata_bridge_pkg::DC_SRST];
    assign sns = sense(res_i.result);

    always_comb begin
        next_state = state;
        next_status = status;
        next_error = error;
        next_count = count;
        next_lba_low = lba_low;
        next_lba_mid = lba_mid;
        next_lba_high = lba_high;
        next_device = device;
        next_devctl = devctl;
        next_asc_q = asc_q;
        next_command = command;
        next_packet_op = packet_op;
        next_pkt_words = pkt_words;
        next_init_cnt = init_cnt;
        next_slave_present = slave_present;
        next_lock_pin = lock_pin;
        next_issue = 1'b0;
        next_ack = wb_cyc_i & wb_stb_i & ~ack;
        next_rdata = rdata;

        // registers software writes; busy blocks all but device control
        if (wr && idx == ata_bridge_pkg::IDX_ALT_STATUS) begin
            next_devctl = wb_dat_i[7:0];
        end
        if (wr && !status[ata_bridge_pkg::ST_BSY]) begin
            case (idx)
                ata_bridge_pkg::IDX_COUNT: next_count = wb_dat_i[7:0];
                ata_bridge_pkg::IDX_LBA_LOW: next_lba_low = wb_dat_i[7:0];
                ata_bridge_pkg::IDX_LBA_MID: next_lba_mid = wb_dat_i[7:0];
                ata_bridge_pkg::IDX_LBA_HIGH: next_lba_high = wb_dat_i[7:0];
                ata_bridge_pkg::IDX_DEVICE: next_device = wb_dat_i[7:0];
                default: ;
            endcase
        end

        case (state)
            ata_bridge_pkg::ST_WAIT_LOCK: begin
                next_status = 8'h80;
                if (lock_s) begin
                    next_lock_pin = 1'b1;
                    next_status[ata_bridge_pkg::ST_BSY] = 1'b1;
                    next_state = ata_bridge_pkg::ST_INIT;
                end
            end
            ata_bridge_pkg::ST_INIT: begin
                next_init_cnt = init_cnt + 16'h0001;
                if (init_cnt == 16'(INIT_CYCLES - 1)) begin
                    next_slave_present = ~dasp_s;
                    next_status = 8'h00;
                    next_status[ata_bridge_pkg::ST_DRDY] = 1'b1;
                    next_state = ata_bridge_pkg::ST_IDLE;
                end
            end
            ata_bridge_pkg::ST_IDLE: begin
                // relied on: command writes while busy are dropped
                if (wr && idx == ata_bridge_pkg::IDX_STATUS) begin
                    next_command = wb_dat_i[7:0];
                    next_error = 8'h00;
                    if (wb_dat_i[7:0] == ata_bridge_pkg::CMD_PACKET) begin
                        next_status = 8'h48;
                        next_pkt_words = 3'h0;
                        next_state = ata_bridge_pkg::ST_PACKET;
                    end else begin
                        // every code incl. identify and set features
                        next_status = 8'h80;
                        next_issue = 1'b1;
                        next_state = ata_bridge_pkg::ST_EXEC;
                    end
                end
            end
            ata_bridge_pkg::ST_PACKET: begin
                if (wr && idx == ata_bridge_pkg::IDX_DATA && word_ok) begin
                    if (pkt_words == 3'h0) begin
                        next_packet_op = wb_dat_i[7:0];
                    end
                    next_pkt_words = pkt_words + 3'h1;
                    if (pkt_words == ata_bridge_pkg::PKT_WORDS - 3'h1) begin
                        next_status = 8'h80;
                        next_issue = 1'b1;
                        next_state = ata_bridge_pkg::ST_EXEC;
                    end
                end
            end
            ata_bridge_pkg::ST_EXEC: begin
                // busy holds while storage naks
                if (res_i.done) begin
                    next_status = 8'h40;
                    next_state = ata_bridge_pkg::ST_IDLE;
                    if (res_i.result != ata_bridge_pkg::RES_OK) begin
                        next_status[ata_bridge_pkg::ST_ERR] = 1'b1;
                        if (command == ata_bridge_pkg::CMD_PACKET) begin
                            next_error = {sns[19:16], 4'h4};
                            next_asc_q = sns[15:0];
                        end else begin
                            next_error = ata_error(res_i.result);
                        end
                    end
                end
            end
            default: begin
                next_state = ata_bridge_pkg::ST_IDLE;
            end
        endcase

        if (abort && init_done) begin
            next_status = 8'h40;
            next_error = 8'h00;
            next_issue = 1'b0;
            next_state = ata_bridge_pkg::ST_IDLE;
        end

        if (next_ack && !wb_we_i) begin
            next_rdata = 32'h0000_0000;
            case (idx)
                ata_bridge_pkg::IDX_ERROR: next_rdata[7:0] = error;
                ata_bridge_pkg::IDX_COUNT: next_rdata[7:0] = count;
                ata_bridge_pkg::IDX_LBA_LOW: next_rdata[7:0] = lba_low;
                ata_bridge_pkg::IDX_LBA_MID: next_rdata[7:0] = lba_mid;
                ata_bridge_pkg::IDX_LBA_HIGH: next_rdata[7:0] = lba_high;
                ata_bridge_pkg::IDX_DEVICE: next_rdata[7:0] = device;
                ata_bridge_pkg::IDX_STATUS: next_rdata[7:0] = status;
                ata_bridge_pkg::IDX_ALT_STATUS: next_rdata[7:0] = status;
                ata_bridge_pkg::IDX_SENSE: next_rdata[15:0] = asc_q;
                ata_bridge_pkg::IDX_INFO: begin
                    next_rdata[1:0] = {slave_present, init_done};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ata_bridge_pkg::ST_WAIT_LOCK;
            status <= 8'h80;
            error <= 8'h00;
            count <= 8'h00;
            lba_low <= 8'h00;
            lba_mid <= 8'h00;
            lba_high <= 8'h00;
            device <= 8'h00;
            devctl <= 8'h00;
            asc_q <= 16'h0000;
            command <= 8'h00;
            packet_op <= 8'h00;
            pkt_words <= 3'h0;
            init_cnt <= 16'h0000;
            slave_present <= 1'b0;
            lock_pin <= 1'b0;
            issue <= 1'b0;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
        end else begin
            state <= next_state;
            status <= next_status;
            error <= next_error;
            count <= next_count;
            lba_low <= next_lba_low;
            lba_mid <= next_lba_mid;
            lba_high <= next_lba_high;
            device <= next_device;
            devctl <= next_devctl;
            asc_q <= next_asc_q;
            command <= next_command;
            packet_op <= next_packet_op;
            pkt_words <= next_pkt_words;
            init_cnt <= next_init_cnt;
            slave_present <= next_slave_present;
            lock_pin <= next_lock_pin;
            issue <= next_issue;
            rdata <= next_rdata;
            ack <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    logic active;
    assign active = status[ata_bridge_pkg::ST_BSY] |
                    status[ata_bridge_pkg::ST_DRQ];
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign general_port_pin_thirteen_o = lock_pin;
    assign dasp_oe_o = init_done;
    assign dasp_o = ~active;
    assign cmd_valid_o = issue;
    assign cmd_o.is_packet = (command == ata_bridge_pkg::CMD_PACKET);
    assign cmd_o.code = command;
    assign cmd_o.packet_op = packet_op;
    assign cmd_o.chs = ~device[ata_bridge_pkg::DEV_LBA];
    assign cmd_o.count = count;
    assign cmd_o.address = {device[3:0], lba_high, lba_mid, lba_low};

endmodule

// [testbench/ata_bridge_status_reporting_checker.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ata_bridge_status_reporting_checker #(
    parameter int INIT_CYCLES = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic dasp_o,
    input wire logic dasp_oe_o,
    input wire logic general_port_pin_thirteen_o,
    input wire logic cmd_valid_o,
    input wire ata_bridge_pkg::res_s res_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence req_seen;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence cmd_done;
        res_i.done && dasp_oe_o;
    endsequence
    chk_ack_answer: assert property (req_seen |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_upper_zero: assert property (wb_ack_o && !wb_we_i |->
        wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
    chk_dasp_busy: assert property (cmd_valid_o |-> !dasp_o && dasp_oe_o)
        else $error("dasp not low during command");
    chk_dasp_free: assert property (cmd_done |-> ##[1:2] dasp_o)
        else $error("dasp not high after completion");
    chk_init_sense: assert property (!dasp_oe_o |-> !cmd_valid_o)
        else $error("command issued during init");
    chk_lock_first: assert property ($rose(dasp_oe_o) |->
        general_port_pin_thirteen_o) else $error("init ended before lock");
    chk_lock_stays: assert property (general_port_pin_thirteen_o |=>
        general_port_pin_thirteen_o) else $error("lock pin dropped");
    chk_init_span: assert property ($rose(general_port_pin_thirteen_o) |->
        !dasp_oe_o [*3]) else $error("init too short");
endmodule
bind ata_bridge_status_reporting ata_bridge_status_reporting_checker #(
    .INIT_CYCLES(INIT_CYCLES)
) checker_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dasp_o(dasp_o), .dasp_oe_o(dasp_oe_o),
    .general_port_pin_thirteen_o(general_port_pin_thirteen_o),
    .cmd_valid_o(cmd_valid_o), .res_i(res_i)
);

// [testbench/ata_bridge_status_reporting_test.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ata_bridge_status_reporting_test;
    logic clock_i = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [6:0] wb_adr = 7'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic host_reset_n = 1'b1;
    logic pll_lock = 1'b0;
    logic dasp_pin = 1'b0;
    logic dasp_o;
    logic dasp_oe_o;
    logic lock_pin;
    logic cmd_valid_o;
    ata_bridge_pkg::cmd_s cmd_o;
    ata_bridge_pkg::cmd_s seen;
    ata_bridge_pkg::res_s res;
    ata_bridge_pkg::result_e result = ata_bridge_pkg::RES_OK;
    logic [3:0] delay = 4'h0;
    logic stall = 1'b0;
    int seed = 32'hd54a;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    ata_bridge_status_reporting #(.INIT_CYCLES(4)) uut (
        .clock_i(clock_i), .resetn_i(resetn), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pll_lock_i(pll_lock),
        .host_reset_n_i(host_reset_n), .dasp_i(dasp_pin), .dasp_o(dasp_o),
        .dasp_oe_o(dasp_oe_o), .general_port_pin_thirteen_o(lock_pin),
        .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .res_i(res)
    );
    storage_model partner (
        .clock_i(clock_i), .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o),
        .result_i(result), .delay_i(delay), .stall_i(stall),
        .res_o(res), .seen_o(seen)
    );
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen_v,
                         input logic [31:0] want);
        checked++;
        if (seen_v !== want) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, want, seen_v);
        end
    endtask
    task automatic bus(input logic we, input logic [4:0] idx,
                       input logic [15:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hf;
        wb_dat <= {16'h0000, d};
        do begin
            @(posedge clock_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ata_err(input logic [3:0] r);
        case (r)
            4'h0: return 8'h00;
            4'h4: return 8'h14;
            4'h5: return 8'h84;
            4'h6: return 8'h20;
            4'h7: return 8'h02;
            default: return 8'h04;
        endcase
    endfunction
    // sense key in upper byte, asc in lower byte
    function automatic logic [15:0] sense(input logic [3:0] r);
        case (r)
            4'h8, 4'h9: return 16'h0408;
            4'h6, 4'ha: return 16'h0628;
            4'h3, 4'h7, 4'hb: return 16'h023a;
            4'h1: return 16'h0520;
            default: return 16'h0b00;
        endcase
    endfunction
    task automatic run_cmd(input logic [7:0] code, input logic [7:0] op,
                           input logic [3:0] r);
        logic [31:0] q;
        logic [15:0] s;
        logic chs_bit;
        int n;
        s = sense(r);
        chs_bit = 1'($random(seed));
        result <= ata_bridge_pkg::result_e'(r);
        delay <= 4'($random(seed));
        bus(1'b1, ata_bridge_pkg::IDX_DEVICE, {9'h000, ~chs_bit, 6'h00}, q);
        bus(1'b1, ata_bridge_pkg::IDX_STATUS, {8'h00, code}, q);
        if (code == ata_bridge_pkg::CMD_PACKET) begin
            bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
            check("drq status", q, 32'h48);
            for (n = 0; n < 6; n++) begin
                bus(1'b1, ata_bridge_pkg::IDX_DATA, {8'h00, op}, q);
            end
        end
        bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
        check("busy status", q, 32'h80);
        check("dasp busy", {dasp_oe_o, dasp_o}, 32'h2);
        check("code", seen.code, code);
        check("chs", seen.chs, chs_bit);
        if (code == ata_bridge_pkg::CMD_PACKET) begin
            check("packet op", seen.packet_op, op);
        end
        n = 0;
        while (q[7] === 1'b1 && n < 100) begin
            bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
            n++;
        end
        check("end status", q, 32'h40 | 32'(r != 4'h0));
        check("dasp idle", dasp_o, 32'h1);
        bus(1'b0, ata_bridge_pkg::IDX_ERROR, 16'h0000, q);
        if (code != ata_bridge_pkg::CMD_PACKET) begin
            check("error", q, {24'h0, ata_err(r)});
        end else if (r != 4'h0) begin
            check("error", q, {24'h0, s[11:8], 4'h4});
            bus(1'b0, ata_bridge_pkg::IDX_SENSE, 16'h0000, q);
            check("sense", q, {16'h0, s[7:0], 8'h00});
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [7:0] codes [3];
        int i;
        codes[0] = ata_bridge_pkg::CMD_IDENTIFY;
        codes[1] = ata_bridge_pkg::CMD_SET_FEATURES;
        codes[2] = ata_bridge_pkg::CMD_IDENTIFY_PKT;
        repeat (16) @(posedge clock_i);
        resetn <= 1'b1;
        dasp_pin <= 1'($random(seed));
        bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
        check("init status", q, 32'h80);
        check("dasp sensing", dasp_oe_o, 32'h0);
        check("lock low", lock_pin, 32'h0);
        pll_lock <= 1'b1;
        i = 0;
        while (q[7] === 1'b1 && i < 100) begin
            bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
            i++;
        end
        check("ready status", q, 32'h40);
        check("lock pin", lock_pin, 32'h1);
        bus(1'b0, ata_bridge_pkg::IDX_INFO, 16'h0000, q);
        check("slave seen", q, {30'h0, ~dasp_pin, 1'b1});
        bus(1'b0, 5'h1f, 16'h0000, q);
        check("unmapped", q, 32'h0);
        for (i = 0; i < 12; i++) begin
            run_cmd(codes[i % 3], 8'h00, 4'(i));
            run_cmd(ata_bridge_pkg::CMD_PACKET, i[0] ?
                ata_bridge_pkg::PKT_READ_CAPACITY :
                ata_bridge_pkg::PKT_INQUIRY, 4'(i));
        end
        stall <= 1'b1;
        bus(1'b1, ata_bridge_pkg::IDX_STATUS, 16'h00ec, q);
        repeat (30) @(posedge clock_i);
        bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
        check("nak busy", q, 32'h80);
        host_reset_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        host_reset_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
        check("reset exit", q, 32'h40);
        bus(1'b1, ata_bridge_pkg::IDX_STATUS, 16'h00ec, q);
        bus(1'b1, ata_bridge_pkg::IDX_ALT_STATUS, 16'h0004, q);
        bus(1'b0, ata_bridge_pkg::IDX_STATUS, 16'h0000, q);
        check("soft reset", q, 32'h40);
        stop_test();
    end
endmodule

// [testbench/storage_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// far side: storage device answering each issued command unless stalled
module storage_model (
    input wire logic clock_i,
    input wire logic cmd_valid_i,
    input wire ata_bridge_pkg::cmd_s cmd_i,
    input wire ata_bridge_pkg::result_e result_i,
    input wire logic [3:0] delay_i,
    input wire logic stall_i,
    output ata_bridge_pkg::res_s res_o,
    output ata_bridge_pkg::cmd_s seen_o
);
    logic pending = 1'b0;
    logic [4:0] count = 5'h00;
    initial res_o = '0;
    always @(posedge clock_i) begin
        res_o.done <= 1'b0;
        // released result lines flip every cycle
        res_o.result <= ata_bridge_pkg::result_e'(~res_o.result);
        if (cmd_valid_i) begin
            seen_o <= cmd_i;
            pending <= 1'b1;
            count <= {1'b0, delay_i} + 5'h08;
        end else if (stall_i) begin
            pending <= 1'b0;
        end else if (pending && count == 5'h00) begin
            pending <= 1'b0;
            res_o.done <= 1'b1;
            res_o.result <= result_i;
        end else if (pending) begin
            count <= count - 5'h01;
        end
    end
endmodule
